// file: logic/ttc_ctrl_status.sv
// control register pair, burst timer and status flags of the tone transceiver
`timescale 1ns/100ps
`include "ttc_defines.svh"

// Notes on behaviour
// - burst mode runs while the burst-disable bit of control B is low
// - each transmit write gives one tone burst then an equal silent pause
// - end of pause sets transmit-empty and raises the interrupt if enabled in DTMF mode
// - call progress mode doubles burst and pause to 102 ms
// - without burst mode the tone follows the tone output enable bit only
// - test mode in DTMF mode puts the late steer flag on the interrupt pin
// - single/dual bit high gives a single tone, low a tone pair
// - column/row bit picks column tone when high, row tone when low
// - status bit 0 sets with transmit-empty or receive-full, clears on read
// - transmit-empty sets after a pause, clears on read, held clear off burst
// - receive-full sets on a valid decoded digit, clears on status read
// - late steer sets on valid tone absence, clears on tone pair, read-proof
// - control writes go to B once after select-B was set, then back to A
// - interrupt pin pulls low on digit or transmit-ready when enabled in DTMF
// - control A bit 1 picks call progress mode, which blocks tone detection
module ttc_ctrl_status
   import ttc_pkg::*;
#(
   parameter int TICK_CYCLES = `TTC_TICK_CYCLES,
   parameter int BURST_MS    = `TTC_BURST_MS,
   parameter int CP_BURST_MS = `TTC_CP_BURST_MS
)(
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       registerSelectLine,
   input  wire logic       wrStrobe_n,
   input  wire logic       rdStrobe_n,
   input  wire logic [3:0] dataIn,
   output logic      [3:0] dataOut,
   output logic            dataOe,
   input  wire logic [3:0] rxDigit,
   input  wire logic       digitValid,
   input  wire logic       steerAbsent,
   input  wire logic       steerPresent,
   input  wire logic       cpSquare,
   output logic      [3:0] txDigit,
   output logic            toneOn,
   output logic            toneSingle,
   output logic            toneColumn,
   output logic            intTonePinOut,
   output logic            intTonePinOe
);
   // pins: rs, wr, rd, data, square wave pass two flops
   logic [7:0]  sync1_reg;
   logic [7:0]  sync2_reg;
   logic        wrPrev_reg;
   logic        rdPrev_reg;
   logic [3:0]  dataHold_reg;
   logic [3:0]  dataHold_next;
   logic        rsHold_reg;
   logic        rsHold_next;
   logic        rsS;
   logic        wrLowS;
   logic        rdLowS;
   logic [3:0]  dataS;
   logic        cpS;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 8'h06;
         sync2_reg <= 8'h06;
         wrPrev_reg <= 1'b1;
         rdPrev_reg <= 1'b1;
      end else begin
         sync1_reg <= {cpSquare, dataIn, rdStrobe_n, wrStrobe_n, registerSelectLine};
         sync2_reg <= sync1_reg;
         wrPrev_reg <= sync2_reg[1];
         rdPrev_reg <= sync2_reg[2];
      end
   end

   assign rsS    = sync2_reg[0];
   assign wrLowS = ~sync2_reg[1];
   assign rdLowS = ~sync2_reg[2];
   assign dataS  = sync2_reg[6:3];
   assign cpS    = sync2_reg[7];

   logic wrEnd;
   logic rdEnd;
   logic wrCtrl;
   logic wrTx;
   logic rdStat;
   // writes take effect as the strobe rises, with data held while it was low
   assign wrEnd  = wrLowS == 1'b0 && wrPrev_reg == 1'b0;
   assign rdEnd  = rdLowS == 1'b0 && rdPrev_reg == 1'b0;
   assign wrCtrl = wrEnd & rsHold_reg;
   assign wrTx   = wrEnd & ~rsHold_reg;
   assign rdStat = rdEnd & rsHold_reg;

   // control register pair sharing one address
   ttc_cra_s   cra_reg;
   ttc_cra_s   cra_next;
   ttc_crb_s   crb_reg;
   ttc_crb_s   crb_next;
   logic [3:0] txDigit_reg;
   logic [3:0] txDigit_next;

   always_comb begin
      dataHold_next = dataHold_reg;
      rsHold_next   = rsHold_reg;
      cra_next      = cra_reg;
      crb_next      = crb_reg;
      txDigit_next  = txDigit_reg;
      if (wrLowS || rdLowS) begin
         rsHold_next = rsS;
      end
      if (wrLowS) begin
         dataHold_next = dataS;
      end
      if (wrCtrl) begin
         if (cra_reg.controlBSelect) begin
            crb_next = ttc_crb_s'(dataHold_reg);
            cra_next.controlBSelect = 1'b0;
         end else begin
            cra_next = ttc_cra_s'(dataHold_reg);
            cra_next.controlBSelect = dataHold_reg[`TTC_CRA_SELB_BIT];
         end
      end
      if (wrTx) begin
         txDigit_next = dataHold_reg;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dataHold_reg <= 4'h0;
         rsHold_reg   <= 1'b0;
         cra_reg      <= ttc_cra_s'(`TTC_CRA_RST);
         crb_reg      <= ttc_crb_s'(`TTC_CRB_RST);
         txDigit_reg  <= 4'h0;
      end else begin
         dataHold_reg <= dataHold_next;
         rsHold_reg   <= rsHold_next;
         cra_reg      <= cra_next;
         crb_reg      <= crb_next;
         txDigit_reg  <= txDigit_next;
      end
   end

   // burst timer: millisecond enable plus burst/pause counter
   ttc_burst_e state_reg;
   ttc_burst_e state_next;
   logic [31:0] tickCnt_reg;
   logic [31:0] tickCnt_next;
   logic [7:0]  msCnt_reg;
   logic [7:0]  msCnt_next;
   logic        tick;
   logic        phaseEnd;
   logic        pauseDone;
   logic [7:0]  limit;

   assign tick  = tickCnt_reg == 32'(TICK_CYCLES - 1);
   assign limit = cra_reg.progressModeSelect ? 8'(CP_BURST_MS) : 8'(BURST_MS);
   assign phaseEnd  = tick && msCnt_reg == limit - 8'h01;
   assign pauseDone = state_reg == ST_PAUSE && phaseEnd;

   always_comb begin
      state_next   = state_reg;
      tickCnt_next = tick ? 32'h0 : tickCnt_reg + 32'h1;
      msCnt_next   = tick ? msCnt_reg + 8'h01 : msCnt_reg;
      unique case (state_reg)
         ST_IDLE: begin
            msCnt_next = 8'h00;
         end
         ST_TONE: begin
            if (phaseEnd) begin
               state_next = ST_PAUSE;
               msCnt_next = 8'h00;
            end
         end
         ST_PAUSE: begin
            if (phaseEnd) begin
               state_next = ST_IDLE;
               msCnt_next = 8'h00;
            end
         end
      endcase
      // a new digit restarts timing from a clean millisecond
      if (wrTx) begin
         state_next   = ST_TONE;
         tickCnt_next = 32'h0;
         msCnt_next   = 8'h00;
      end
      if (crb_reg.burstDisable) begin
         state_next = ST_IDLE;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg   <= ST_IDLE;
         tickCnt_reg <= 32'h0;
         msCnt_reg   <= 8'h00;
      end else begin
         state_reg   <= state_next;
         tickCnt_reg <= tickCnt_next;
         msCnt_reg   <= msCnt_next;
      end
   end

   // status flags; a set in the clearing cycle wins
   ttc_status_s status_reg;
   ttc_status_s status_next;
   logic        rxSet;

   assign rxSet = digitValid & ~cra_reg.progressModeSelect;

   always_comb begin
      status_next = status_reg;
      status_next.txEmpty = (status_reg.txEmpty & ~rdStat) | pauseDone;
      if (crb_reg.burstDisable) begin
         status_next.txEmpty = 1'b0;
      end
      status_next.rxFull  = (status_reg.rxFull & ~rdStat) | rxSet;
      status_next.irqFlag = (status_reg.irqFlag & ~rdStat) | rxSet | pauseDone;
      if (steerAbsent) begin
         status_next.lateSteerFlag = 1'b1;
      end else if (steerPresent) begin
         status_next.lateSteerFlag = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= ttc_status_s'(`TTC_STAT_RST);
      end else begin
         status_reg <= status_next;
      end
   end

   // registered outputs
   logic [3:0] dataOut_next;
   logic       dataOe_next;
   logic       toneOn_next;
   logic       pull_next;

   always_comb begin
      dataOe_next  = rdLowS;
      dataOut_next = 4'h0;
      if (rdLowS) begin
         dataOut_next = rsS ? 4'(status_reg) : rxDigit;
      end
      if (crb_reg.burstDisable) begin
         toneOn_next = cra_reg.toneOutputEnable;
      end else begin
         toneOn_next = cra_reg.toneOutputEnable && state_reg == ST_TONE;
      end
      // open drain: enable means pulling the pin low
      // test mode shows the steer flag whether or not interrupts are on
      if (crb_reg.testMode && !cra_reg.progressModeSelect) begin
         pull_next = ~status_reg.lateSteerFlag;
      end else if (!cra_reg.irqEnable) begin
         pull_next = 1'b0;
      end else if (cra_reg.progressModeSelect) begin
         pull_next = ~cpS;
      end else begin
         pull_next = status_reg.irqFlag;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dataOut       <= 4'h0;
         dataOe        <= 1'b0;
         txDigit       <= 4'h0;
         toneOn        <= 1'b0;
         toneSingle    <= 1'b0;
         toneColumn    <= 1'b0;
         intTonePinOut <= 1'b0;
         intTonePinOe  <= 1'b0;
      end else begin
         dataOut       <= dataOut_next;
         dataOe        <= dataOe_next;
         txDigit       <= txDigit_reg;
         toneOn        <= toneOn_next;
         toneSingle    <= crb_reg.singleSelect;
         toneColumn    <= crb_reg.columnSelect;
         intTonePinOut <= 1'b0;
         intTonePinOe  <= pull_next;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_burst_off_idle: assert property (
      crb_reg.burstDisable |=> state_reg == ST_IDLE)
      else $error("burst timer running with burst disabled");
   a_tone_to_pause: assert property (
      state_reg == ST_TONE && phaseEnd && !wrTx && !crb_reg.burstDisable
      |=> state_reg == ST_PAUSE && msCnt_reg == 8'h00)
      else $error("burst did not turn into pause");
   a_empty_after_pause: assert property (
      pauseDone && !crb_reg.burstDisable |=> status_reg.txEmpty && status_reg.irqFlag)
      else $error("pause end did not set transmit empty");
   a_cp_long_burst: assert property (
      cra_reg.progressModeSelect |-> limit == 8'(CP_BURST_MS))
      else $error("call progress burst length wrong");
   a_manual_tone: assert property (
      crb_reg.burstDisable ##1 crb_reg.burstDisable |-> toneOn == $past(cra_reg.toneOutputEnable))
      else $error("tone does not follow enable bit");
   a_test_pin: assert property (
      !cra_reg.progressModeSelect && crb_reg.testMode
      |=> intTonePinOe == !$past(status_reg.lateSteerFlag))
      else $error("test mode pin not following steer flag");
   a_tone_shape: assert property (
      ##1 toneSingle == $past(crb_reg.singleSelect) && toneColumn == $past(crb_reg.columnSelect))
      else $error("tone selection outputs stale");
   a_read_clear: assert property (
      rdStat && !rxSet && !pauseDone
      |=> !status_reg.irqFlag && !status_reg.rxFull && !status_reg.txEmpty)
      else $error("status flags not cleared by read");
   a_rx_set: assert property (
      rxSet |=> status_reg.rxFull && status_reg.irqFlag)
      else $error("digit did not set receive full");
   a_steer_hold: assert property (
      rdStat && !steerAbsent && !steerPresent
      |=> status_reg.lateSteerFlag == $past(status_reg.lateSteerFlag))
      else $error("status read changed steer flag");
   a_select_b: assert property (
      wrCtrl && cra_reg.controlBSelect |=> !cra_reg.controlBSelect ##1 !cra_reg.controlBSelect)
      else $error("select B not dropped after control B write");
   a_irq_pin: assert property (
      cra_reg.irqEnable && !cra_reg.progressModeSelect && !crb_reg.testMode
      && status_reg.irqFlag |=> intTonePinOe)
      else $error("interrupt pin not pulled low");
   a_cp_no_detect: assert property (
      cra_reg.progressModeSelect && !status_reg.rxFull |=> !status_reg.rxFull)
      else $error("digit taken in call progress mode");
   a_status_drive: assert property (
      rdLowS && rsS |=> dataOe && dataOut == 4'($past(status_reg)))
      else $error("status not driven on read");

   c_burst_done: cover property (pauseDone);
   c_read_rx: cover property (rxSet ##[1:20] rdStat);
   c_crb_write: cover property (wrCtrl && cra_reg.controlBSelect);
endmodule : ttc_ctrl_status

// file: logic/ttc_defines.svh
// constants for the tone transceiver control and status bank
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH
`define TTC_CLK_NS        20
`define TTC_TICK_NS       1000000
`define TTC_TICK_CYCLES   ((`TTC_TICK_NS) / (`TTC_CLK_NS))
`define TTC_BURST_MS      51
`define TTC_CP_BURST_MS   102
`define TTC_CRA_SELB_BIT  3
`define TTC_CRA_RST       4'h0
`define TTC_CRB_RST       4'h0
`define TTC_STAT_RST      4'h0
`endif

// file: logic/ttc_pkg.sv
// types for the tone transceiver control and status bank
package ttc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_TONE  = 3'b010,
      ST_PAUSE = 3'b100
   } ttc_burst_e;

   typedef struct packed {
      logic controlBSelect;
      logic irqEnable;
      logic progressModeSelect;
      logic toneOutputEnable;
   } ttc_cra_s;

   typedef struct packed {
      logic columnSelect;
      logic singleSelect;
      logic testMode;
      logic burstDisable;
   } ttc_crb_s;

   typedef struct packed {
      logic lateSteerFlag;
      logic rxFull;
      logic txEmpty;
      logic irqFlag;
   } ttc_status_s;
endpackage : ttc_pkg

// file: tb/ttc_host_model.sv
// host microcontroller model on the register strobe pins
`timescale 1ns/100ps
module ttc_host_model (
   input  wire logic       core_clk,
   output logic            registerSelectLine,
   output logic            wrStrobe_n,
   output logic            rdStrobe_n,
   output logic      [3:0] dataIn,
   input  wire logic [3:0] dataOut,
   input  wire logic       dataOe
);
   initial begin
      registerSelectLine = 1'b1;
      wrStrobe_n = 1'b1;
      rdStrobe_n = 1'b1;
      dataIn = 4'h0;
   end

   // strobes stay 4 cycles low, 6 high: the pin sync needs 3 each way
   task automatic wr(input logic rs, input logic [3:0] d);
      @(negedge core_clk);
      registerSelectLine = rs;
      dataIn = d;
      wrStrobe_n = 1'b0;
      repeat (4) @(negedge core_clk);
      wrStrobe_n = 1'b1;
      repeat (6) @(negedge core_clk);
      // bus driven to the complement: no stale value left on it
      dataIn = ~d;
   endtask : wr

   task automatic rd(input logic rs, output logic [3:0] q);
      @(negedge core_clk);
      registerSelectLine = rs;
      rdStrobe_n = 1'b0;
      repeat (4) @(negedge core_clk);
      q = dataOe ? dataOut : 4'hx;
      rdStrobe_n = 1'b1;
      repeat (6) @(negedge core_clk);
   endtask : rd
endmodule : ttc_host_model

// file: tb/tb_top.sv
// self-checking bench for the tone transceiver control and status bank
`timescale 1ns/100ps
module tb_top;
   import ttc_pkg::*;
   localparam int TICKS = 10;
   logic       core_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       rsLine, wrN, rdN, dataOe, toneOn, toneSingle, toneColumn, pinOut, pinOe;
   logic [3:0] dataIn, dataOut, txDigit, q;
   logic [3:0] rxDigit = 4'h0;
   logic       digitValid = 1'b0;
   logic       steerAbsent = 1'b0;
   logic       steerPresent = 1'b0;
   logic       cpSquare = 1'b0;
   int         n_errors = 0;
   int         check_count = 0;

   always #10 core_clk = ~core_clk;

   ttc_ctrl_status #(.TICK_CYCLES(TICKS), .BURST_MS(3), .CP_BURST_MS(6)) ttc_ctrl_status_i (
      .core_clk(core_clk), .reset_n(reset_n), .registerSelectLine(rsLine),
      .wrStrobe_n(wrN), .rdStrobe_n(rdN), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe(dataOe), .rxDigit(rxDigit), .digitValid(digitValid),
      .steerAbsent(steerAbsent), .steerPresent(steerPresent), .cpSquare(cpSquare),
      .txDigit(txDigit), .toneOn(toneOn), .toneSingle(toneSingle),
      .toneColumn(toneColumn), .intTonePinOut(pinOut), .intTonePinOe(pinOe));

   ttc_host_model ttc_host_model_i (
      .core_clk(core_clk), .registerSelectLine(rsLine), .wrStrobe_n(wrN),
      .rdStrobe_n(rdN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

   task automatic results;
      if (n_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic w(input logic rs, input logic [3:0] d);
      ttc_host_model_i.wr(rs, d);
   endtask : w

   task automatic r(input logic rs);
      ttc_host_model_i.rd(rs, q);
   endtask : r

   // one-cycle pulse on {digitValid, steerAbsent, steerPresent}
   task automatic pulse(input logic [2:0] m);
      @(negedge core_clk);
      {digitValid, steerAbsent, steerPresent} = m;
      @(negedge core_clk);
      {digitValid, steerAbsent, steerPresent} = 3'b000;
      repeat (3) @(negedge core_clk);
   endtask : pulse

   // cycles the tone stays on, after waiting for it to start
   task automatic toneLen(output int n);
      n = 0;
      while (toneOn !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      n = 0;
      while (toneOn === 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 300) begin
         n_errors++;
         results();
      end
   endtask : toneLen

   task automatic initSeq;
      r(1'b1);
      check(q, 4'h0);
      w(1'b1, 4'h0);
      w(1'b1, 4'h0);
      w(1'b1, 4'h8);
      w(1'b1, 4'h0);
      r(1'b1);
      check(q, 4'h0);
   endtask : initSeq

   task automatic selectTones;
      for (int i = 0; i < 4; i++) begin
         w(1'b1, 4'h8);
         w(1'b1, {i[1:0], 2'b01});
         check({2'h0, toneColumn, toneSingle}, {2'h0, i[1:0]});
      end
      // control B already taken, so this lands in control A
      w(1'b1, 4'h0);
      check({2'h0, toneColumn, toneSingle}, 4'h3);
   endtask : selectTones

   task automatic burst;
      int n;
      w(1'b1, 4'hd);
      w(1'b1, 4'h0);
      fork
         w(1'b0, 4'h7);
         toneLen(n);
      join
      check(txDigit, 4'h7);
      check({3'h0, n inside {[29:31]}}, 4'h1);
      n = 0;
      while (pinOe !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      check({3'h0, toneOn}, 4'h0);
      check({3'h0, pinOut}, 4'h0);
      check({3'h0, n inside {[29:33]}}, 4'h1);
      r(1'b1);
      check(q, 4'h3);
      check({3'h0, pinOe}, 4'h0);
      r(1'b1);
      check(q, 4'h0);
   endtask : burst

   task automatic cpBurstThenSteady;
      int n;
      w(1'b1, 4'hb);
      w(1'b1, 4'h0);
      fork
         w(1'b0, 4'h5);
         toneLen(n);
      join
      check({3'h0, n inside {[59:61]}}, 4'h1);
      pulse(3'b100);
      r(1'b1);
      check(q, 4'h0);
      // burst off before the long pause ends: transmit-empty must stay clear
      // stay in call progress mode so the pause is not cut short
      w(1'b1, 4'hb);
      w(1'b1, 4'h1);
      check({3'h0, toneOn}, 4'h1);
      repeat (120) @(negedge core_clk);
      check({3'h0, toneOn}, 4'h1);
      r(1'b1);
      check(q, 4'h0);
      w(1'b1, 4'h0);
      check({3'h0, toneOn}, 4'h0);
   endtask : cpBurstThenSteady

   task automatic rxSteer;
      // interrupts off: test mode must still drive the pin
      w(1'b1, 4'h8);
      w(1'b1, 4'h3);
      pulse(3'b010);
      check({3'h0, pinOe}, 4'h0);
      pulse(3'b001);
      check({3'h0, pinOe}, 4'h1);
      pulse(3'b010);
      r(1'b1);
      check(q, 4'h8);
      r(1'b1);
      check(q, 4'h8);
      w(1'b1, 4'hc);
      w(1'b1, 4'h1);
      rxDigit = 4'h5;
      pulse(3'b100);
      check({3'h0, pinOe}, 4'h1);
      r(1'b1);
      check(q, 4'hd);
      r(1'b0);
      check(q, 4'h5);
      r(1'b1);
      check(q, 4'h8);
   endtask : rxSteer

   initial begin
      repeat (6) @(negedge core_clk);
      reset_n = 1'b1;
      initSeq();
      selectTones();
      burst();
      cpBurstThenSteady();
      rxSteer();
      results();
   end
endmodule : tb_top
